// ==== xcvr_mode_ctrl.v ====
// Top of the serial transceiver mode control: AHB-Lite registers, two transceivers, ECL pair, lamps.
// Assumes one 250 MHz clock, synchronous active-high reset, pins asynchronous to the clock.
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "xcvr_ctrl_defines.vh"
module xcvr_mode_ctrl #(
	parameter NX = 2,
	parameter DW = 16
) (
	// Clock and reset
	input wire CLK_I,
	input wire SRST_I,
	// AHB-Lite slave
	input wire HSEL_I,
	input wire [7:0] HADDR_I,
	input wire [1:0] HTRANS_I,
	input wire HWRITE_I,
	input wire [2:0] HSIZE_I,
	input wire [31:0] HWDATA_I,
	input wire HREADY_I,
	output wire [31:0] HRDATA_O,
	output wire HREADYOUT_O,
	output wire HRESP_O,
	// Transceiver controls and data, one bit per transceiver
	output wire [NX-1:0] SLEW_FAST_O,
	output wire [NX-1:0] DIFFERENTIAL_MODE_SELECT_O,
	output wire [NX-1:0] ONE_PAIR_DIRECTION_SELECT_O,
	output wire [NX-1:0] XCVR_DATA_IN_FIRST_O,
	output wire [NX-1:0] XCVR_DATA_IN_SECOND_O,
	input wire [NX-1:0] XCVR_RECV_OUT_FIRST_I,
	input wire [NX-1:0] XCVR_RECV_OUT_SECOND_I,
	// ECL pair, lamps, board reset request
	output wire DIFF_OUT_DRIVE_O,
	input wire DIFF_IN_DECODED_I,
	output wire [4:0] INDICATOR_LAMP_N_O,
	output wire BOARD_RESET_REQUEST_N_O
);
	////////////////////////////////////////////////////////////////////////////
	// Bit-time limits in clock cycles; a divider below the limit is clamped.
	// Quotients are formed at full width, then cut to the divider width on purpose.
	localparam [31:0] DIV_232_FAST_W = `CLK_HZ / `BAUD_MAX_232_FAST;
	localparam [31:0] DIV_SLOW_W = `CLK_HZ / `BAUD_MAX_SLOW;
	localparam [31:0] DIV_DIFF_FAST_W = `CLK_HZ / `BAUD_MAX_DIFF_FAST;
	localparam [DW-1:0] DIV_232_FAST = DIV_232_FAST_W[DW-1:0];
	localparam [DW-1:0] DIV_SLOW = DIV_SLOW_W[DW-1:0];
	localparam [DW-1:0] DIV_DIFF_FAST = DIV_DIFF_FAST_W[DW-1:0];

	reg [1:0] mode_q [0:NX-1];
	reg [NX-1:0] slew_q;
	reg [NX-1:0] den_q;
	reg [NX-1:0] rts_q;
	reg [NX-1:0] txgo_q;
	reg [7:0] txd_q [0:NX-1];
	reg [7:0] txd2_q [0:NX-1];
	reg [NX-1:0] pend_q;
	reg [DW-1:0] div_q;
	reg ecl_q;
	reg [4:0] lamp_q;
	reg brst_q;
	reg [NX-1:0] ovr_q;
	reg [NX-1:0] rxv_q;
	reg [7:0] rxd_q [0:NX-1];

	wire [DW-1:0] div_eff [0:NX-1];
	wire [NX-1:0] busy;
	wire [NX-1:0] busy2;
	wire [NX-1:0] rxv_a;
	wire [NX-1:0] rxv_b;
	wire [7:0] rxd_a [0:NX-1];
	wire [7:0] rxd_b [0:NX-1];
	wire [NX-1:0] tx_a;
	wire [NX-1:0] tx_b;
	wire [NX-1:0] rxs1;
	wire [NX-1:0] rxs2;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: two flops before any logic reads a pin.
	reg [NX-1:0] r1_m_q;
	reg [NX-1:0] r1_s_q;
	reg [NX-1:0] r2_m_q;
	reg [NX-1:0] r2_s_q;
	reg ecl_m_q;
	reg ecl_s_q;
	always @(posedge CLK_I)
	begin
		r1_m_q <= XCVR_RECV_OUT_FIRST_I;
		r1_s_q <= r1_m_q;
		r2_m_q <= XCVR_RECV_OUT_SECOND_I;
		r2_s_q <= r2_m_q;
		ecl_m_q <= DIFF_IN_DECODED_I;
		ecl_s_q <= ecl_m_q;
	end
	assign rxs1 = r1_s_q;
	assign rxs2 = r2_s_q;

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, always OKAY, write data taken in data phase.
	reg wr_q;
	reg rd_q;
	reg [7:0] ad_q;
	reg [31:0] rdata_d;
	wire take = HSEL_I & HREADY_I & HTRANS_I[1];
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;
	always @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			ad_q <= 8'h00;
		end
		else
		begin
			wr_q <= take & HWRITE_I;
			rd_q <= take & ~HWRITE_I;
			ad_q <= HADDR_I;
		end
	end
	wire [NX-1:0] sel_chan;
	wire ctrl_wr = wr_q && ad_q == `OFS_CTRL;
	wire tx_wr = wr_q && ad_q == `OFS_TXDATA;
	wire rx_rd = rd_q && ad_q == `OFS_RXDATA;

	////////////////////////////////////////////////////////////////////////////
	// Per-transceiver control, pin mapping and UARTs.
	genvar g;
	generate
		for (g = 0; g < NX; g = g + 1)
		begin : chan
			// Control byte g: [1:0] mode, [2] fast slew, [3] driver enable, [4] RTS.
			wire [7:0] cb = HWDATA_I[8*g+7:8*g];
			wire idle = ~busy[g] & ~busy2[g] & ~pend_q[g] & ~den_q[g];
			wire diff = (mode_q[g] != `MODE_RS232);
			wire [DW-1:0] lim = !slew_q[g] ? DIV_SLOW : (diff ? DIV_DIFF_FAST : DIV_232_FAST);
			assign div_eff[g] = (div_q < lim) ? lim : div_q;
			always @(posedge CLK_I)
			begin
				if (SRST_I)
				begin
					mode_q[g] <= `MODE_RS232;
					slew_q[g] <= 1'b0;
					den_q[g] <= 1'b0;
					rts_q[g] <= 1'b1;
					pend_q[g] <= 1'b0;
					txd_q[g] <= 8'h00;
					txd2_q[g] <= 8'h00;
					txgo_q[g] <= 1'b0;
					rxv_q[g] <= 1'b0;
					ovr_q[g] <= 1'b0;
					rxd_q[g] <= 8'h00;
				end
				else
				begin
					if (ctrl_wr)
					begin
						// Mode and slew only move with the driver off, nothing pending or sending, and path two not receiving.
						if (idle && cb[1:0] != 2'h3)
						begin
							mode_q[g] <= cb[1:0];
							slew_q[g] <= cb[2];
						end
						den_q[g] <= cb[3];
						rts_q[g] <= cb[4];
					end
					txgo_q[g] <= 1'b0;
					if (tx_wr && HWDATA_I[16+g])
					begin
						txd_q[g] <= HWDATA_I[7:0];
						txd2_q[g] <= HWDATA_I[15:8];
						pend_q[g] <= 1'b1;
					end
					else if (pend_q[g] && !busy[g] && !txgo_q[g])
					begin
						txgo_q[g] <= 1'b1;
						pend_q[g] <= 1'b0;
					end
					// A new byte wins over a read that clears the flag in the same cycle.
					if (rxv_a[g] | rxv_b[g])
					begin
						rxd_q[g] <= diff ? rxd_b[g] : rxd_a[g];
						rxv_q[g] <= 1'b1;
						ovr_q[g] <= ovr_q[g] | rxv_q[g];
					end
					else if (rx_rd)
						rxv_q[g] <= 1'b0;
				end
			end
			// RS232 receive uses path one, differential modes path two.
			xcvr_uart_chan #(.DW(DW)) u_a (
				.clk_i(CLK_I),
				.rst_i(SRST_I),
				.div_i(div_eff[g]),
				.tx_go_i(txgo_q[g]),
				.tx_data_i(txd_q[g]),
				.tx_o(tx_a[g]),
				.tx_busy_o(busy[g]),
				.rx_i(diff ? 1'b1 : rxs1[g]),
				.rx_data_o(rxd_a[g]),
				.rx_valid_o(rxv_a[g]),
				.rx_busy_o()
			);
			// Second channel: RS232 second line, or differential receiver.
			xcvr_uart_chan #(.DW(DW)) u_b (
				.clk_i(CLK_I),
				.rst_i(SRST_I),
				.div_i(div_eff[g]),
				.tx_go_i(txgo_q[g] & ~diff),
				.tx_data_i(txd2_q[g]),
				.tx_o(tx_b[g]),
				.tx_busy_o(),
				.rx_i(rxs2[g]),
				.rx_data_o(rxd_b[g]),
				.rx_valid_o(rxv_b[g]),
				.rx_busy_o(busy2[g])
			);
			assign sel_chan[g] = diff;
			assign SLEW_FAST_O[g] = slew_q[g];
			assign DIFFERENTIAL_MODE_SELECT_O[g] = diff;
			assign ONE_PAIR_DIRECTION_SELECT_O[g] = (mode_q[g] == `MODE_HALF);
			assign XCVR_DATA_IN_FIRST_O[g] = tx_a[g];
			// RS232 second line carries data or RTS; differential modes carry the driver enable.
			assign XCVR_DATA_IN_SECOND_O[g] = diff ? den_q[g] : (rts_q[g] & tx_b[g]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Pin register, ECL, lamps and board reset request.
	always @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			div_q <= `BAUD_RESET;
			ecl_q <= 1'b0;
			lamp_q <= `LAMP_RESET;
			brst_q <= 1'b1;
		end
		else
		begin
			if (wr_q && ad_q == `OFS_BAUD)
				div_q <= HWDATA_I[DW-1:0];
			if (wr_q && ad_q == `OFS_PINS)
			begin
				ecl_q <= HWDATA_I[0];
				lamp_q <= HWDATA_I[5:1];
				// Reset request needs a deliberate zero plus key to avoid resetting the carrier.
				brst_q <= ~(HWDATA_I[31:24] == 8'hA5 && !HWDATA_I[6]);
			end
		end
	end
	assign DIFF_OUT_DRIVE_O = ecl_q;
	assign INDICATOR_LAMP_N_O = lamp_q;
	assign BOARD_RESET_REQUEST_N_O = brst_q;

	////////////////////////////////////////////////////////////////////////////
	// Read mux; reads are combinational in the data phase from registered address.
	integer i;
	always @*
	begin
		rdata_d = 32'h0000_0000;
		case (ad_q)
			`OFS_CTRL:
				for (i = 0; i < NX; i = i + 1)
					rdata_d[8*i +: 8] = {3'h0, rts_q[i], den_q[i], slew_q[i], mode_q[i]};
			`OFS_BAUD:
				rdata_d[DW-1:0] = div_q;
			`OFS_RXDATA:
				for (i = 0; i < NX; i = i + 1)
					rdata_d[8*i +: 8] = rxd_q[i];
			`OFS_STATUS:
				for (i = 0; i < NX; i = i + 1)
					rdata_d[8*i +: 8] = {2'h0, sel_chan[i], busy2[i], pend_q[i] | busy[i], ovr_q[i], rxv_q[i], 1'b0};
			`OFS_PINS:
				rdata_d[7:0] = {ecl_s_q, brst_q, lamp_q, ecl_q};
			default:
				rdata_d = 32'h0000_0000;
		endcase
	end
	assign HRDATA_O = rd_q ? rdata_d : 32'h0000_0000;
endmodule
`default_nettype wire

// ==== xcvr_ctrl_defines.vh ====
// Constants for the serial transceiver mode control block.
// Assumes inclusion by bare name from the design files in this folder.
`ifndef XCVR_CTRL_DEFINES_VH
`define XCVR_CTRL_DEFINES_VH
`define CLK_HZ 32'd250_000_000
`define BAUD_MAX_232_FAST 32'd1_000_000
`define BAUD_MAX_SLOW 32'd250_000
`define BAUD_MAX_DIFF_FAST 32'd10_000_000
`define MODE_RS232 2'h0
`define MODE_FULL 2'h1
`define MODE_HALF 2'h2
`define OFS_CTRL 8'h00
`define OFS_BAUD 8'h04
`define OFS_TXDATA 8'h08
`define OFS_RXDATA 8'h0C
`define OFS_STATUS 8'h10
`define OFS_PINS 8'h14
`define CTRL_RESET 32'h0000_0000
`define BAUD_RESET 16'h03E8
`define LAMP_RESET 5'h1F
`endif

// ==== xcvr_uart_chan.v ====
// One UART channel: 8N1 transmitter and receiver, one-cycle baud ticks.
// Assumes rx_i is already synchronised to CLK; div sets cycles per bit.
`timescale 1ns/10ps
`default_nettype none
module xcvr_uart_chan #(
	parameter DW = 16
) (
	input wire clk_i,
	input wire rst_i,
	input wire [DW-1:0] div_i,
	input wire tx_go_i,
	input wire [7:0] tx_data_i,
	output reg tx_o,
	output wire tx_busy_o,
	input wire rx_i,
	output reg [7:0] rx_data_o,
	output reg rx_valid_o,
	output wire rx_busy_o
);
	reg [DW-1:0] tcnt_q;
	reg [3:0] tbit_q;
	reg [8:0] tsh_q;
	reg [DW-1:0] rcnt_q;
	reg [3:0] rbit_q;
	reg [7:0] rsh_q;
	assign tx_busy_o = (tbit_q != 4'h0);
	assign rx_busy_o = (rbit_q != 4'h0);
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tcnt_q <= {DW{1'b0}};
			tbit_q <= 4'h0;
			tsh_q <= 9'h1FF;
			tx_o <= 1'b1;
		end
		else if (tbit_q == 4'h0)
		begin
			tx_o <= 1'b1;
			if (tx_go_i)
			begin
				tsh_q <= {tx_data_i, 1'b0};
				tbit_q <= 4'hA;
				tcnt_q <= div_i;
			end
		end
		else
		begin
			tx_o <= tsh_q[0];
			if (tcnt_q <= {{(DW-1){1'b0}}, 1'b1})
			begin
				tcnt_q <= div_i;
				tsh_q <= {1'b1, tsh_q[8:1]};
				tbit_q <= tbit_q - 4'h1;
			end
			else
				tcnt_q <= tcnt_q - {{(DW-1){1'b0}}, 1'b1};
		end
	end
	// Receiver samples at mid-bit; a start bit that is gone at mid-bit is treated as a glitch.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rcnt_q <= {DW{1'b0}};
			rbit_q <= 4'h0;
			rsh_q <= 8'h00;
			rx_data_o <= 8'h00;
			rx_valid_o <= 1'b0;
		end
		else
		begin
			rx_valid_o <= 1'b0;
			if (rbit_q == 4'h0)
			begin
				if (!rx_i)
				begin
					rbit_q <= 4'hA;
					rcnt_q <= {1'b0, div_i[DW-1:1]};
				end
			end
			else if (rcnt_q <= {{(DW-1){1'b0}}, 1'b1})
			begin
				rcnt_q <= div_i;
				rbit_q <= rbit_q - 4'h1;
				if (rbit_q == 4'hA && rx_i)
					rbit_q <= 4'h0;
				else if (rbit_q == 4'h1)
				begin
					rx_data_o <= rsh_q;
					rx_valid_o <= rx_i;
				end
				else if (rbit_q != 4'hA)
					rsh_q <= {rx_i, rsh_q[7:1]};
			end
			else
				rcnt_q <= rcnt_q - {{(DW-1){1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire

// ==== xcvr_mode_ctrl_asserts.sv ====
// Checker for the transceiver mode control top: bus answer, reset levels, select changes, transmit start.
// Assumes it is bound to xcvr_mode_ctrl and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "xcvr_ctrl_defines.vh"
module xcvr_mode_ctrl_asserts #(
	parameter NX = 2
) (
	// Clock, reset and bus
	input wire CLK_I,
	input wire SRST_I,
	input wire HSEL_I,
	input wire [7:0] HADDR_I,
	input wire [1:0] HTRANS_I,
	input wire HWRITE_I,
	input wire [31:0] HWDATA_I,
	input wire HREADY_I,
	input wire [31:0] HRDATA_O,
	input wire HREADYOUT_O,
	input wire HRESP_O,
	// Transceiver and board pins
	input wire [NX-1:0] SLEW_FAST_O,
	input wire [NX-1:0] DIFFERENTIAL_MODE_SELECT_O,
	input wire [NX-1:0] ONE_PAIR_DIRECTION_SELECT_O,
	input wire [NX-1:0] XCVR_DATA_IN_FIRST_O,
	input wire [NX-1:0] XCVR_DATA_IN_SECOND_O,
	input wire DIFF_OUT_DRIVE_O,
	input wire [4:0] INDICATOR_LAMP_N_O,
	input wire BOARD_RESET_REQUEST_N_O
);
	wire addr_ph = HSEL_I && HREADY_I && HTRANS_I[1];
	default clocking dc @(posedge CLK_I);
	endclocking
	default disable iff (SRST_I);
	////////////////////////////////////////////////////////////////////////////////
	a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
		else $error("bus answer not ready or not okay");
	a_reset_pins: assert property (
		$fell(SRST_I) |-> BOARD_RESET_REQUEST_N_O && INDICATOR_LAMP_N_O == 5'h1F && !DIFF_OUT_DRIVE_O)
		else $error("board pins not at reset level");
	a_reset_lines: assert property (
		$fell(SRST_I) |-> SLEW_FAST_O == '0 && DIFFERENTIAL_MODE_SELECT_O == '0 && &XCVR_DATA_IN_FIRST_O)
		else $error("transceiver lines not at reset level");
	a_half_in_diff: assert property (
		(ONE_PAIR_DIRECTION_SELECT_O & ~DIFFERENTIAL_MODE_SELECT_O) == '0)
		else $error("one-pair select outside differential mode");
	a_mode_hold: assert property (
		!$past(SRST_I) |-> ((DIFFERENTIAL_MODE_SELECT_O ^ $past(DIFFERENTIAL_MODE_SELECT_O))
		& $past(DIFFERENTIAL_MODE_SELECT_O & XCVR_DATA_IN_SECOND_O)) == '0)
		else $error("mode changed with driver on");
	a_slew_hold: assert property (
		!$past(SRST_I) |-> ((SLEW_FAST_O ^ $past(SLEW_FAST_O))
		& $past(DIFFERENTIAL_MODE_SELECT_O & XCVR_DATA_IN_SECOND_O)) == '0)
		else $error("slew changed with driver on");
	a_tx_start: assert property (
		addr_ph && HWRITE_I && HADDR_I == `OFS_TXDATA ##1 HWDATA_I[16] |-> ##[1:4] !XCVR_DATA_IN_FIRST_O[0])
		else $error("no start bit after transmit request");
	a_unmapped_read: assert property (
		addr_ph && !HWRITE_I && HADDR_I > `OFS_PINS |=> HRDATA_O == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ==== xcvr_line_model.sv ====
// Behavioural model of the two line transceivers and their cable.
// Assumes the first line outputs are looped back to the first line inputs in RS232 mode.
`timescale 1ns/10ps
`default_nettype none
module xcvr_line_model (
	// Controls and data from the block, far-end pair level
	input wire logic clk_i,
	input wire logic [1:0] diff_i,
	input wire logic [1:0] half_i,
	input wire logic [1:0] tx1_i,
	input wire logic [1:0] tx2_i,
	input wire logic [1:0] pair_i,
	// Receiver outputs
	output wire logic [1:0] rx1_o,
	output wire logic [1:0] rx2_o
);
	logic tog = 1'b0;
	always @(posedge clk_i)
		tog <= ~tog;
	// An unused receiver output toggles, so any use of it shows.
	assign rx1_o = (diff_i & {2{tog}}) | (~diff_i & tx1_i);
	// With the driver on, a one-pair link hears its own transmitter.
	assign rx2_o = (diff_i & half_i & tx2_i & tx1_i) | (~(diff_i & half_i & tx2_i) & pair_i);
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the transceiver mode control: registers, selects, serial lines, pins.
// Assumes the line model stands for both transceivers.
`timescale 1ns/10ps
`default_nettype none
`include "xcvr_ctrl_defines.vh"
module testbench;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic hwr = 1'b0;
	logic ecl = 1'b1;
	logic [1:0] htr = 2'h0;
	logic [1:0] sb = 2'h3;
	logic [7:0] ha = 8'h00;
	logic [31:0] hwd = 32'h0000_0000;
	logic [31:0] rd;
	wire [31:0] hrd;
	wire hrdy, hresp, eclo, rqn;
	wire [1:0] slew, dif, half, d1, d2, r1, r2;
	wire [4:0] lamp;
	int miscompares = 0;
	int cmp_count = 0;
	logic [8:0] rows [7] = '{9'h101, 9'h149, 9'h048, 9'h05C, 9'h06E, 9'h07E, 9'h026};
	xcvr_mode_ctrl #(.NX(2), .DW(16)) u_xcvr_mode_ctrl (.CLK_I(clk), .SRST_I(srst), .HSEL_I(hsel), .HADDR_I(ha),
		.HTRANS_I(htr), .HWRITE_I(hwr), .HSIZE_I(3'h2), .HWDATA_I(hwd), .HREADY_I(hrdy), .HRDATA_O(hrd),
		.HREADYOUT_O(hrdy), .HRESP_O(hresp), .SLEW_FAST_O(slew), .DIFFERENTIAL_MODE_SELECT_O(dif),
		.ONE_PAIR_DIRECTION_SELECT_O(half), .XCVR_DATA_IN_FIRST_O(d1), .XCVR_DATA_IN_SECOND_O(d2),
		.XCVR_RECV_OUT_FIRST_I(r1), .XCVR_RECV_OUT_SECOND_I(r2), .DIFF_OUT_DRIVE_O(eclo),
		.DIFF_IN_DECODED_I(ecl), .INDICATOR_LAMP_N_O(lamp), .BOARD_RESET_REQUEST_N_O(rqn));
	xcvr_line_model u_xcvr_line_model (.clk_i(clk), .diff_i(dif), .half_i(half), .tx1_i(d1), .tx2_i(d2),
		.pair_i(sb), .rx1_o(r1), .rx2_o(r2));
	initial
		forever #2 clk = ~clk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	// Read data is taken from the cycle before the edge, so it never races the register update.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic rdy;
		hsel <= 1'b1;
		htr <= 2'h2;
		ha <= a;
		hwr <= w;
		do
		begin
			@(negedge clk);
			rdy = hrdy;
			@(posedge clk);
		end
		while (rdy !== 1'b1);
		hsel <= 1'b0;
		htr <= 2'h0;
		hwd <= d;
		do
		begin
			@(negedge clk);
			rdy = hrdy;
			rd = hrd;
			@(posedge clk);
		end
		while (rdy !== 1'b1);
	endtask
	function automatic logic [31:0] pw(input logic e, input logic q, input logic [4:0] l, input logic [3:0] m);
		return {17'h0_0000, e, q, l, {2{m[3]}}, {2{m[2]}}, {2{m[1]}}, {2{m[0]}}};
	endfunction
	task automatic pins(input logic [31:0] e);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk({17'h0_0000, eclo, rqn, lamp, slew, dif, half, d2}, e);
		@(posedge clk);
	endtask
	// Lines are looked at on the falling edge, away from the edge that launches them.
	task automatic ser_chk(input logic [7:0] b, input int dv, input bit sel);
		logic [9:0] r;
		int n;
		n = 0;
		while ((sel ? d2[0] : d1[0]) !== 1'b0 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		repeat (dv / 2) @(posedge clk);
		for (int i = 0; i < 10; i++)
		begin
			@(negedge clk);
			r[i] = sel ? d2[0] : d1[0];
			repeat (dv) @(posedge clk);
		end
		chk({22'h0, r}, {22'h0, 1'b1, b, 1'b0});
	endtask
	task automatic send_b(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			sb <= {2{f[i]}};
			repeat (25) @(posedge clk);
		end
	endtask
	task automatic fin(input string s);
		$display("%s over: %0d compares, %0d mismatches", s, cmp_count, miscompares);
	endtask
	task automatic test_done;
		$display("compares %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100_000;
		miscompares++;
		test_done();
	end
	initial
	begin
		// The design under test is taken as configured over the AHB-Lite bus.
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		pins(pw(1'b0, 1'b1, 5'h1F, 4'h1));
		bus(1'b0, `OFS_BAUD, 32'h0);
		chk(rd, {16'h0000, `BAUD_RESET});
		bus(1'b0, `OFS_PINS, 32'h0);
		chk(rd, 32'h0000_00FE);
		fin("reset");
		foreach (rows[i])
		begin
			bus(1'b1, `OFS_CTRL, {16'h0000, 3'h0, rows[i][8:4], 3'h0, rows[i][8:4]});
			pins(pw(1'b0, 1'b1, 5'h1F, rows[i][3:0]));
		end
		fin("modes");
		bus(1'b1, `OFS_CTRL, 32'h0000_0E0E);
		pins(pw(1'b0, 1'b1, 5'h1F, 4'hF));
		bus(1'b1, `OFS_CTRL, 32'h0000_0404);
		pins(pw(1'b0, 1'b1, 5'h1F, 4'hE));
		ecl <= 1'b0;
		bus(1'b1, `OFS_PINS, 32'h0000_0015);
		pins(pw(1'b1, 1'b1, 5'h0A, 4'hE));
		bus(1'b0, `OFS_PINS, 32'h0);
		chk(rd, 32'h0000_0055);
		bus(1'b1, `OFS_PINS, 32'hA500_003E);
		pins(pw(1'b0, 1'b0, 5'h1F, 4'hE));
		bus(1'b1, 8'h20, 32'hFFFF_FFFF);
		bus(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, `OFS_PINS, 32'h0);
		chk(rd, 32'h0000_003E);
		fin("pins");
		bus(1'b1, `OFS_CTRL, 32'h0000_060D);
		bus(1'b1, `OFS_BAUD, 32'h0);
		bus(1'b1, `OFS_TXDATA, 32'h0001_0055);
		fork
			ser_chk(8'h55, 25, 1'b0);
			send_b(8'hA3);
		join
		repeat (30) @(posedge clk);
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk(rd & 32'h0000_2222, 32'h0000_2222);
		bus(1'b0, `OFS_RXDATA, 32'h0);
		chk(rd & 32'h0000_FFFF, 32'h0000_A3A3);
		fin("serial");
		bus(1'b1, `OFS_CTRL, 32'h0000_0605);
		bus(1'b1, `OFS_CTRL, 32'h0000_1414);
		bus(1'b1, `OFS_TXDATA, 32'h0001_C35A);
		fork
			ser_chk(8'h5A, 250, 1'b0);
			ser_chk(8'hC3, 250, 1'b1);
		join
		repeat (300) @(posedge clk);
		bus(1'b0, `OFS_RXDATA, 32'h0);
		chk(rd & 32'h0000_00FF, 32'h0000_005A);
		fin("rs232");
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		pins(pw(1'b0, 1'b1, 5'h1F, 4'h1));
		fin("second reset");
		test_done();
	end
endmodule
bind xcvr_mode_ctrl xcvr_mode_ctrl_asserts #(.NX(NX)) u_chk (.*);
`default_nettype wire
